// ### modbus_array_table_access.sv
// Modbus slave access logic for the shared array table, integer and float views
`timescale 1ns/1ps
module modbus_array_table_access
  import modbus_table_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1
)
(
  // Clock, reset, enable
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // Write enable setting
  input  wire logic        cfg_valid,
  input  wire logic        cfg_value,
  // Register word request
  input  wire logic        req_valid,
  input  wire logic        req_first,
  input  wire logic [7:0]  req_func,
  input  wire logic [15:0] req_reg,
  input  wire logic [15:0] req_wdata,
  // Register word answer
  output logic             resp_valid,
  output logic      [15:0] resp_data,
  output logic             resp_exception,
  output logic      [7:0]  resp_exc_code,
  output logic             array_write_enable
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  localparam logic [15:0] TABLE_LIMIT = LARGE_VARIANT ? TABLE_DEPTH_LARGE :
                                                        TABLE_DEPTH_SMALL;

  logic [31:0]       table_mem [0:TABLE_DEPTH_LARGE-1];
  half_e             half_pos;
  half_e             next_half_pos;
  half_e             cur_half;
  logic [15:0]       hold_hi;
  logic [15:0]       next_hold_hi;
  logic              next_resp_valid;
  logic [15:0]       next_resp_data;
  logic              next_resp_exception;
  logic [7:0]        next_resp_exc_code;
  logic              next_array_write_enable;
  logic [15:0]       int_off;
  logic [15:0]       flt_off;
  logic [15:0]       flt_lo;
  logic              is_int;
  logic              is_flt;
  logic [ELEM_W-1:0] elem;
  logic [31:0]       rd_word;
  logic [31:0]       rd_float;
  logic [31:0]       wr_fixed;
  logic              mem_we;
  logic [31:0]       mem_wdata;

  // Low half of a float pair names the element one register below
  assign cur_half = req_first ? HALF_HIGH : half_pos;
  assign flt_lo   = (cur_half == HALF_LOW) ? 16'h0001 : 16'h0000;
  assign int_off  = req_reg - INT_BASE;
  assign flt_off  = req_reg - FLOAT_BASE - flt_lo;
  // Flat linear decode; array partitioning is purely a software view
  assign is_int   = (req_reg >= INT_BASE) && (int_off < TABLE_LIMIT);
  assign is_flt   = (req_reg >= FLOAT_BASE + flt_lo) && (flt_off < TABLE_LIMIT);
  assign elem     = is_int ? int_off[ELEM_W-1:0] : flt_off[ELEM_W-1:0];
  assign rd_word  = table_mem[elem];

  fixed_to_float fixed_to_float_inst (
    .fixed      (rd_word),
    .float_bits (rd_float)
  );

  float_to_fixed float_to_fixed_inst (
    .float_bits ({hold_hi, req_wdata}),
    .fixed      (wr_fixed)
  );

  // ----------------------------------------------------------------
  // Request handling
  // ----------------------------------------------------------------
  always_comb begin
    next_resp_valid         = 1'b0;
    next_resp_data          = 16'h0000;
    next_resp_exception     = 1'b0;
    next_resp_exc_code      = EXC_NONE;
    next_half_pos           = half_pos;
    next_hold_hi            = hold_hi;
    next_array_write_enable = array_write_enable;
    mem_we                  = 1'b0;
    mem_wdata               = rd_word;
    if (cfg_valid) begin
      next_array_write_enable = cfg_value;
    end
    if (req_valid) begin
      next_resp_valid = 1'b1;
      next_half_pos   = (cur_half == HALF_HIGH) ? HALF_LOW : HALF_HIGH;
      if ((req_func != FC_READ_HOLDING) && (req_func != FC_WRITE_MULTIPLE)) begin
        next_resp_exception = 1'b1;
        next_resp_exc_code  = EXC_ILLEGAL_FUNCTION;
      end else if (!(is_int || is_flt)) begin
        next_resp_exception = 1'b1;
        next_resp_exc_code  = EXC_ILLEGAL_ADDRESS;
      end else if ((req_func == FC_WRITE_MULTIPLE) && !array_write_enable) begin
        next_resp_exception = 1'b1;
        next_resp_exc_code  = EXC_WRITE_LOCKED;
      end else if (req_func == FC_READ_HOLDING) begin
        if (is_int) begin
          next_resp_data = rd_word[INT_MSB:INT_LSB];
        end else if (cur_half == HALF_HIGH) begin
          next_resp_data = rd_float[INT_MSB:INT_LSB];
        end else begin
          next_resp_data = rd_float[HALF_MSB:0];
        end
      end else begin
        next_resp_data = req_wdata;
        if (is_int) begin
          mem_we    = 1'b1;
          mem_wdata = {req_wdata, rd_word[FRAC_MSB:0]};
        end else if (cur_half == HALF_HIGH) begin
          next_hold_hi = req_wdata;
        end else begin
          mem_we    = 1'b1;
          mem_wdata = wr_fixed;
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      resp_valid         <= 1'b0;
      resp_data          <= 16'h0000;
      resp_exception     <= 1'b0;
      resp_exc_code      <= EXC_NONE;
      array_write_enable <= WE_RESET;
      half_pos           <= HALF_HIGH;
      hold_hi            <= 16'h0000;
    end else if (clk_en) begin
      resp_valid         <= next_resp_valid;
      resp_data          <= next_resp_data;
      resp_exception     <= next_resp_exception;
      resp_exc_code      <= next_resp_exc_code;
      array_write_enable <= next_array_write_enable;
      half_pos           <= next_half_pos;
      hold_hi            <= next_hold_hi;
    end
  end

  // Table contents are data, not control, and keep no reset value
  always_ff @(posedge core_clk) begin
    if (clk_en && mem_we) begin
      table_mem[elem] <= mem_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_int_write;
    clk_en && req_valid && (req_func == FC_WRITE_MULTIPLE) && is_int && array_write_enable
      && !cfg_valid;
  endsequence

  sequence s_int_readback;
    clk_en && req_valid && (req_func == FC_READ_HOLDING) && (req_reg == $past(req_reg));
  endsequence

  sequence s_float_commit;
    clk_en && req_valid && (req_func == FC_WRITE_MULTIPLE) && is_flt && array_write_enable
      && (cur_half == HALF_LOW);
  endsequence

  sequence s_alias_read;
    clk_en && req_valid && (req_func == FC_READ_HOLDING) && is_int
      && (elem == $past(elem));
  endsequence

  a_locked_write_refused: assert property (
    @(posedge core_clk) disable iff (reset)
    clk_en && req_valid && (req_func == FC_WRITE_MULTIPLE) && (is_int || is_flt)
      && !array_write_enable
    |=> resp_valid && resp_exception && (resp_exc_code == EXC_WRITE_LOCKED))
    else $error("write accepted while writes are disabled");

  a_read_served: assert property (
    @(posedge core_clk) disable iff (reset)
    clk_en && req_valid && (req_func == FC_READ_HOLDING) && (is_int || is_flt)
    |=> resp_valid && !resp_exception)
    else $error("in range read was not served");

  a_enable_holds: assert property (
    @(posedge core_clk) disable iff (reset)
    !(clk_en && cfg_valid) |=> $stable(array_write_enable))
    else $error("write enable changed without a setting");

  a_one_answer_each: assert property (
    @(posedge core_clk) disable iff (reset)
    clk_en ##1 clk_en |-> (resp_valid == $past(req_valid)))
    else $error("answer does not match one request per cycle");

  a_int_keeps_value: assert property (
    @(posedge core_clk) disable iff (reset)
    s_int_write ##1 s_int_readback |=> (resp_data == $past(req_wdata, 2)) && !resp_exception)
    else $error("integer write did not read back");

  a_range_limit: assert property (
    @(posedge core_clk) disable iff (reset)
    clk_en && req_valid && (req_func == FC_READ_HOLDING)
      && (req_reg >= INT_BASE + TABLE_LIMIT) && (req_reg < FLOAT_BASE)
    |=> resp_exception && (resp_exc_code == EXC_ILLEGAL_ADDRESS))
    else $error("register beyond the table was decoded");

  a_small_float_limit: assert property (
    @(posedge core_clk) disable iff (reset)
    clk_en && req_valid && (req_func == FC_READ_HOLDING) && req_first
      && (req_reg >= FLOAT_BASE + TABLE_LIMIT)
    |=> resp_exception && (resp_exc_code == EXC_ILLEGAL_ADDRESS))
    else $error("float register beyond the table was decoded");

  a_bad_function: assert property (
    @(posedge core_clk) disable iff (reset)
    clk_en && req_valid && (req_func != FC_READ_HOLDING) && (req_func != FC_WRITE_MULTIPLE)
    |=> resp_exception && (resp_exc_code == EXC_ILLEGAL_FUNCTION))
    else $error("unsupported function code was accepted");

  a_float_alias: assert property (
    @(posedge core_clk) disable iff (reset)
    s_float_commit ##1 s_alias_read |=> (resp_data == $past(wr_fixed[INT_MSB:INT_LSB], 2)))
    else $error("float write not visible through integer range");

  // ----------------------------------------------------------------
  // Storage and answer checks
  // ----------------------------------------------------------------
  a_locked_no_store: assert property (
    @(posedge core_clk) disable iff (reset)
    clk_en && req_valid && (req_func == FC_WRITE_MULTIPLE) && !array_write_enable
    |-> !mem_we)
    else $error("table written while writes are disabled");

  a_enable_loads: assert property (
    @(posedge core_clk) disable iff (reset)
    clk_en && cfg_valid |=> (array_write_enable == $past(cfg_value)))
    else $error("write enable did not take the new setting");

  a_write_echo: assert property (
    @(posedge core_clk) disable iff (reset)
    clk_en && req_valid && (req_func == FC_WRITE_MULTIPLE) && (is_int || is_flt)
      && array_write_enable
    |=> resp_valid && !resp_exception && (resp_data == $past(req_wdata)))
    else $error("enabled write was refused or not echoed");

  a_exception_data: assert property (
    @(posedge core_clk) disable iff (reset)
    resp_valid && resp_exception |-> (resp_data == 16'h0000) && (resp_exc_code != EXC_NONE))
    else $error("exception answer carries data");

  a_high_half_held: assert property (
    @(posedge core_clk) disable iff (reset)
    clk_en && req_valid && (req_func == FC_WRITE_MULTIPLE) && is_flt && (cur_half == HALF_HIGH)
    |-> !mem_we)
    else $error("high half of a float stored before its low half");

  a_float_stored: assert property (
    @(posedge core_clk) disable iff (reset)
    s_float_commit |=> (table_mem[$past(elem)] == $past(wr_fixed)))
    else $error("float write did not reach the table");

  a_int_stored: assert property (
    @(posedge core_clk) disable iff (reset)
    s_int_write |=> (table_mem[$past(elem)][INT_MSB:INT_LSB] == $past(req_wdata)))
    else $error("integer write did not reach the table");

  a_bad_address: assert property (
    @(posedge core_clk) disable iff (reset)
    clk_en && req_valid && ((req_func == FC_READ_HOLDING) || (req_func == FC_WRITE_MULTIPLE))
      && !(is_int || is_flt)
    |=> resp_exception && (resp_exc_code == EXC_ILLEGAL_ADDRESS))
    else $error("register outside the table was not refused");

  a_frozen_answers: assert property (
    @(posedge core_clk) disable iff (reset)
    !clk_en |=> $stable(resp_valid) && $stable(resp_data) && $stable(array_write_enable))
    else $error("state moved while the clock enable was low");

endmodule

// ### modbus_table_pkg.sv
// Shared constants for the Modbus array table access block
package modbus_table_pkg;

  // ----------------------------------------------------------------
  // Table geometry and register decode
  // ----------------------------------------------------------------
  localparam int          ELEM_W            = 10;
  localparam logic [15:0] TABLE_DEPTH_LARGE = 16'h03E8;
  localparam logic [15:0] TABLE_DEPTH_SMALL = 16'h0190;
  localparam logic [15:0] INT_BASE          = 16'h03E8;
  localparam logic [15:0] FLOAT_BASE        = 16'h07D0;

  // ----------------------------------------------------------------
  // Element layout: signed fixed point, integer over fraction
  // ----------------------------------------------------------------
  localparam int INT_MSB  = 31;
  localparam int INT_LSB  = 16;
  localparam int FRAC_MSB = 15;
  localparam int HALF_MSB = 15;

  // ----------------------------------------------------------------
  // Function and exception codes
  // ----------------------------------------------------------------
  localparam logic [7:0] FC_READ_HOLDING      = 8'h03;
  localparam logic [7:0] FC_WRITE_MULTIPLE    = 8'h10;
  localparam logic [7:0] EXC_NONE             = 8'h00;
  localparam logic [7:0] EXC_ILLEGAL_FUNCTION = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_ADDRESS  = 8'h02;
  localparam logic [7:0] EXC_WRITE_LOCKED     = 8'h04;

  localparam logic WE_RESET = 1'b0;

  // ----------------------------------------------------------------
  // Single precision float fields
  // ----------------------------------------------------------------
  localparam int         FLT_SIGN     = 31;
  localparam int         FLT_EXP_MSB  = 30;
  localparam int         FLT_EXP_LSB  = 23;
  localparam int         FLT_MANT_MSB = 22;
  localparam int         NORM_LSB     = 8;
  localparam logic [7:0] EXP_UNIT     = 8'h86;
  localparam logic [7:0] EXP_SAT      = 8'h8E;
  localparam logic [7:0] MANT_W       = 8'h18;
  localparam logic [7:0] EXP_FIX_OFS  = 8'h6F;
  localparam logic [31:0] FIX_POS_MAX = 32'h7FFFFFFF;
  localparam logic [31:0] FIX_NEG_MAX = 32'h80000000;

  typedef enum logic {HALF_HIGH, HALF_LOW} half_e;

endpackage

// ### float_to_fixed.sv
// Converts a single precision float into the signed 16.16 element format
`timescale 1ns/1ps
module float_to_fixed
  import modbus_table_pkg::*;
(
  // Conversion
  input  wire logic [31:0] float_bits,
  output logic      [31:0] fixed
);

  logic [7:0]  exp_v;
  logic [7:0]  rsh;
  logic [31:0] mag;
  logic        sat;

  always_comb begin
    exp_v = float_bits[FLT_EXP_MSB:FLT_EXP_LSB];
    rsh   = EXP_UNIT - exp_v;
    mag   = {8'h00, 1'b1, float_bits[FLT_MANT_MSB:0]};
    sat   = 1'b0;
    if (exp_v < EXP_UNIT) begin
      // Below the last fraction bit the value truncates to zero
      mag = (rsh >= MANT_W) ? 32'h00000000 : (mag >> rsh);
    end else if (exp_v >= EXP_SAT) begin
      // Infinity and NaN also saturate; there is no way to store them
      sat = 1'b1;
    end else begin
      mag = mag << (exp_v - EXP_UNIT);
    end
    if (sat) begin
      fixed = float_bits[FLT_SIGN] ? FIX_NEG_MAX : FIX_POS_MAX;
    end else begin
      fixed = float_bits[FLT_SIGN] ? (~mag + 32'h00000001) : mag;
    end
  end

endmodule

// ### fixed_to_float.sv
// Converts a signed 16.16 element into a single precision float
`timescale 1ns/1ps
module fixed_to_float
  import modbus_table_pkg::*;
(
  // Conversion
  input  wire logic [31:0] fixed,
  output logic      [31:0] float_bits
);

  logic [31:0] mag;
  logic [31:0] norm;
  logic [4:0]  msb;

  always_comb begin
    mag  = fixed[FLT_SIGN] ? (~fixed + 32'h00000001) : fixed;
    msb  = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (mag[i]) begin
        msb = 5'(i);
      end
    end
    // Low bits drop by truncation, never rounding
    norm = mag << (5'h1F - msb);
    if (mag == 32'h00000000) begin
      float_bits = 32'h00000000;
    end else begin
      float_bits = {fixed[FLT_SIGN], 8'({3'h0, msb}) + EXP_FIX_OFS,
                    norm[INT_MSB-1:NORM_LSB]};
    end
  end

endmodule

// ### modbus_master_model.sv
// Modbus master model that issues register word requests and gathers the answers
`timescale 1ns/1ps
module modbus_master_model (
  // Clock
  input  wire logic        core_clk,
  // Word request
  output logic             req_valid,
  output logic             req_first,
  output logic      [7:0]  req_func,
  output logic      [15:0] req_reg,
  output logic      [15:0] req_wdata,
  // Word answer
  input  wire logic        resp_valid,
  input  wire logic [15:0] resp_data,
  input  wire logic        resp_exception,
  input  wire logic [7:0]  resp_exc_code
);
  logic [15:0] wd  [3];
  logic [7:0]  fn  [3];
  logic [15:0] rg  [3];
  logic        fs  [3];
  logic [25:0] rsp [3];

  initial begin
    req_valid = 1'b0;
    req_first = 1'b0;
    req_func  = 8'h00;
    req_reg   = 16'h0000;
    req_wdata = 16'h0000;
  end

  // Words leave back to back; each answer is taken one cycle after its word, at the next falling edge
  task automatic play(input int n);
    for (int i = 0; i <= n; i++) begin
      @(negedge core_clk);
      if (i > 0) rsp[i-1] = {resp_valid, resp_exception, resp_exc_code, resp_data};
      if (i < n) begin
        req_valid = 1'b1;
        req_first = fs[i];
        req_func  = fn[i];
        req_reg   = rg[i];
        req_wdata = wd[i];
      end else begin
        // Released lines flip so a stale value can never pass for a live one
        req_valid = 1'b0;
        req_first = ~req_first;
        req_func  = ~req_func;
        req_reg   = ~req_reg;
        req_wdata = ~req_wdata;
      end
    end
  endtask

  // One request of n words in rising register order
  task automatic burst(input logic [7:0] func, input logic [15:0] first_reg, input int n);
    for (int i = 0; i < n; i++) begin
      fs[i] = (i == 0);
      fn[i] = func;
      rg[i] = first_reg + 16'(i);
    end
    play(n);
  endtask
endmodule

// ### modbus_array_table_access_bench.sv
// Self-checking bench for the Modbus array table access block
`timescale 1ns/1ps
module modbus_array_table_access_bench;
  import modbus_table_pkg::*;

  logic        core_clk  = 1'b0;
  logic        reset     = 1'b1;
  logic        clk_en    = 1'b1;
  logic        cfg_valid = 1'b0;
  logic        cfg_value = 1'b0;
  logic        req_valid;
  logic        req_first;
  logic [7:0]  req_func;
  logic [15:0] req_reg;
  logic [15:0] req_wdata;
  logic        resp_valid;
  logic [15:0] resp_data;
  logic        resp_exception;
  logic [7:0]  resp_exc_code;
  logic        array_write_enable;
  logic        resp_valid_small;
  logic [15:0] resp_data_small;
  logic        resp_exception_small;
  logic [7:0]  resp_exc_code_small;
  logic        array_write_enable_small;
  int          n_fail   = 0;
  int          n_checks = 0;

  always #2.5 core_clk = ~core_clk;

  modbus_array_table_access #(.LARGE_VARIANT(1'b1)) modbus_array_table_access_inst (
    .core_clk(core_clk), .reset(reset), .clk_en(clk_en),
    .cfg_valid(cfg_valid), .cfg_value(cfg_value),
    .req_valid(req_valid), .req_first(req_first), .req_func(req_func),
    .req_reg(req_reg), .req_wdata(req_wdata),
    .resp_valid(resp_valid), .resp_data(resp_data), .resp_exception(resp_exception),
    .resp_exc_code(resp_exc_code), .array_write_enable(array_write_enable));

  // Small variant on the same words; its answers are read straight off its outputs
  modbus_array_table_access #(.LARGE_VARIANT(1'b0)) modbus_array_table_access_small_inst (
    .core_clk(core_clk), .reset(reset), .clk_en(clk_en),
    .cfg_valid(cfg_valid), .cfg_value(cfg_value),
    .req_valid(req_valid), .req_first(req_first), .req_func(req_func),
    .req_reg(req_reg), .req_wdata(req_wdata),
    .resp_valid(resp_valid_small), .resp_data(resp_data_small),
    .resp_exception(resp_exception_small), .resp_exc_code(resp_exc_code_small),
    .array_write_enable(array_write_enable_small));

  modbus_master_model modbus_master_model_inst (
    .core_clk(core_clk), .req_valid(req_valid), .req_first(req_first),
    .req_func(req_func), .req_reg(req_reg), .req_wdata(req_wdata),
    .resp_valid(resp_valid), .resp_data(resp_data), .resp_exception(resp_exception),
    .resp_exc_code(resp_exc_code));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [25:0] seen, input logic [25:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  function automatic logic [25:0] ok(input logic [15:0] d);
    return {2'b10, EXC_NONE, d};
  endfunction

  function automatic logic [25:0] ex(input logic [7:0] c);
    return {2'b11, c, 16'h0000};
  endfunction

  function automatic logic [25:0] m(input int i);
    return modbus_master_model_inst.rsp[i];
  endfunction

  function automatic logic [25:0] sm();
    return {resp_valid_small, resp_exception_small, resp_exc_code_small, resp_data_small};
  endfunction

  task automatic set_word(input int i, input logic f, input logic [7:0] c,
                          input logic [15:0] r, input logic [15:0] d);
    modbus_master_model_inst.fs[i] = f;
    modbus_master_model_inst.fn[i] = c;
    modbus_master_model_inst.rg[i] = r;
    modbus_master_model_inst.wd[i] = d;
  endtask

  task automatic go(input logic [7:0] f, input logic [15:0] r, input int n,
                    input logic [15:0] a, input logic [15:0] b);
    modbus_master_model_inst.wd[0] = a;
    modbus_master_model_inst.wd[1] = b;
    modbus_master_model_inst.burst(f, r, n);
  endtask

  task automatic set_we(input logic v);
    @(negedge core_clk);
    cfg_valid = 1'b1;
    cfg_value = v;
    @(negedge core_clk);
    cfg_valid = 1'b0;
    cfg_value = ~v;
    check(26'(array_write_enable), 26'(v));
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check(26'(array_write_enable), 26'(WE_RESET));
    check(26'(resp_valid), 26'h0000000);
  endtask

  task automatic t_int_float();
    set_we(1'b1);
    go(FC_WRITE_MULTIPLE, 16'h03E8, 1, 16'h04D2, 16'h0000);
    check(m(0), ok(16'h04D2));
    go(FC_WRITE_MULTIPLE, 16'h07D1, 2, 16'h42F6, 16'hE978);
    check(m(1), ok(16'hE978));
    go(FC_READ_HOLDING, 16'h03E8, 1, 16'h0000, 16'h0000);
    check(m(0), ok(16'h04D2));
    go(FC_READ_HOLDING, 16'h07D1, 2, 16'h0000, 16'h0000);
    check(m(0), ok(16'h42F6));
    check(m(1), ok(16'hE978));
    go(FC_READ_HOLDING, 16'h03E9, 1, 16'h0000, 16'h0000);
    check(m(0), ok(16'h007B));
    // Integer write keeps the fraction 0x74BC, so the float becomes 5.456
    go(FC_WRITE_MULTIPLE, 16'h03E9, 1, 16'h0005, 16'h0000);
    go(FC_READ_HOLDING, 16'h07D1, 2, 16'h0000, 16'h0000);
    check(m(0), ok(16'h40AE));
    check(m(1), ok(16'h9780));
  endtask

  task automatic t_alias();
    go(FC_WRITE_MULTIPLE, 16'h07D0, 2, 16'h4020, 16'h0000);
    go(FC_READ_HOLDING, 16'h03E8, 1, 16'h0000, 16'h0000);
    check(m(0), ok(16'h0002));
  endtask

  // Separate requests with no gap, so a read meets the write just before it
  task automatic t_back_to_back();
    set_word(0, 1'b1, FC_WRITE_MULTIPLE, 16'h03EA, 16'h1234);
    set_word(1, 1'b1, FC_READ_HOLDING, 16'h03EA, 16'h0000);
    modbus_master_model_inst.play(2);
    check(m(0), ok(16'h1234));
    check(m(1), ok(16'h1234));
    set_word(0, 1'b1, FC_WRITE_MULTIPLE, 16'h07D2, 16'h4148);
    set_word(1, 1'b0, FC_WRITE_MULTIPLE, 16'h07D3, 16'h0000);
    set_word(2, 1'b1, FC_READ_HOLDING, 16'h03EA, 16'h0000);
    modbus_master_model_inst.play(3);
    check(m(1), ok(16'h0000));
    check(m(2), ok(16'h000C));
  endtask

  // Small variant answers still stand on the edge at which go returns
  task automatic t_small();
    go(FC_WRITE_MULTIPLE, 16'h0577, 1, 16'h0042, 16'h0000);
    go(FC_READ_HOLDING, 16'h0577, 1, 16'h0000, 16'h0000);
    check(sm(), ok(16'h0042));
    check(m(0), ok(16'h0042));
    go(FC_READ_HOLDING, 16'h03E8, 1, 16'h0000, 16'h0000);
    check(sm(), ok(16'h0002));
    go(FC_READ_HOLDING, 16'h0578, 1, 16'h0000, 16'h0000);
    check(sm(), ex(EXC_ILLEGAL_ADDRESS));
    go(FC_READ_HOLDING, 16'h0960, 1, 16'h0000, 16'h0000);
    check(sm(), ex(EXC_ILLEGAL_ADDRESS));
    check(26'(array_write_enable_small), 26'(1'b1));
  endtask

  task automatic t_edges();
    go(FC_WRITE_MULTIPLE, 16'h0BB7, 2, 16'h3F80, 16'h0000);
    go(FC_READ_HOLDING, 16'h07CF, 1, 16'h0000, 16'h0000);
    check(m(0), ok(16'h0001));
    go(FC_READ_HOLDING, 16'h0BB7, 2, 16'h0000, 16'h0000);
    check(m(0), ok(16'h3F80));
    check(m(1), ok(16'h0000));
    go(FC_READ_HOLDING, 16'h03E7, 1, 16'h0000, 16'h0000);
    check(m(0), ex(EXC_ILLEGAL_ADDRESS));
    go(FC_READ_HOLDING, 16'h0BB9, 1, 16'h0000, 16'h0000);
    check(m(0), ex(EXC_ILLEGAL_ADDRESS));
  endtask

  task automatic t_codes();
    logic [7:0] codes [6] = '{8'h01, 8'h02, 8'h04, 8'h05, 8'h06, 8'h11};
    foreach (codes[i]) begin
      go(codes[i], 16'h03E8, 1, 16'h0000, 16'h0000);
      check(m(0), ex(EXC_ILLEGAL_FUNCTION));
    end
    // Bad function outranks bad address
    go(8'h06, 16'h03E7, 1, 16'h0000, 16'h0000);
    check(m(0), ex(EXC_ILLEGAL_FUNCTION));
  endtask

  task automatic t_locked();
    set_we(1'b0);
    go(FC_WRITE_MULTIPLE, 16'h03E8, 1, 16'h7777, 16'h0000);
    check(m(0), ex(EXC_WRITE_LOCKED));
    go(FC_WRITE_MULTIPLE, 16'h07D0, 2, 16'h4120, 16'h0000);
    check(m(1), ex(EXC_WRITE_LOCKED));
    go(FC_READ_HOLDING, 16'h03E8, 1, 16'h0000, 16'h0000);
    check(m(0), ok(16'h0002));
  endtask

  task automatic t_freeze();
    @(negedge core_clk);
    clk_en = 1'b0;
    go(FC_READ_HOLDING, 16'h03E8, 1, 16'h0000, 16'h0000);
    check(m(0) >> 25, 26'h0000000);
    clk_en = 1'b1;
  endtask

  initial begin
    repeat (4) @(negedge core_clk);
    reset = 1'b0;
    t_reset();
    t_int_float();
    t_alias();
    t_back_to_back();
    t_edges();
    t_small();
    t_codes();
    t_locked();
    t_freeze();
    final_report();
  end

  // Cuts a hang short
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    final_report();
  end
endmodule
